// ### design/rstopc_clk_div.sv
// reference clock output divider
`timescale 1ns/10ps
module rstopc_clk_div
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // settings
  input wire logic outEnable,
  input wire logic [4:0] divField,
  // pad controls
  output logic refClkOut,
  output logic refClkBypass,
  output logic refClkOe
);

  logic [4:0] cnt_q, cnt_d;
  logic [4:0] lastDiv_q;
  logic clk_q, clk_d;
  logic byp_q, byp_d;
  logic oe_q, oe_d;

  // half period of divField cycles gives f divided by twice the field
  always_comb
  begin
    cnt_d = cnt_q;
    clk_d = clk_q;
    oe_d = outEnable;
    byp_d = outEnable && (divField == 5'd0);
    if (!outEnable || divField == 5'd0 || divField != lastDiv_q)
    begin
      cnt_d = 5'd0;
      clk_d = 1'b0;
    end
    else if (cnt_q == divField - 5'd1)
    begin
      cnt_d = 5'd0;
      clk_d = !clk_q;
    end
    else
    begin
      cnt_d = cnt_q + 5'd1;
    end
  end

  // divider registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= 5'd0;
      lastDiv_q <= 5'd0;
      clk_q <= 1'b0;
      byp_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      lastDiv_q <= divField;
      clk_q <= clk_d;
      byp_q <= byp_d;
      oe_q <= oe_d;
    end
  end

  assign refClkOut = clk_q;
  assign refClkBypass = byp_q;
  assign refClkOe = oe_q;

endmodule

// ### design/rstopc_config.sv
// sync, transmit, clock output and packet configuration bank
`timescale 1ns/10ps
module rstopc_config
  import rstopc_pkg::*;
#(
  parameter int XTAL_KHZ = 12800
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // serial configuration port
  input wire logic spiSck,
  input wire logic spiCs_b,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // sync word detector
  input wire logic syncEnable,
  input wire logic [1:0] syncSize,
  input wire logic [1:0] syncTol,
  input wire logic rxBitValid,
  input wire logic rxBit,
  output logic syncFound,
  // transmitter settings
  output logic [3:0] txCutoffCode,
  output logic [11:0] txCutoffKhz,
  output logic [2:0] txPowerCode,
  output logic signed [7:0] txPowerTenthDbm,
  output logic txFirstIfZero,
  output logic txDeviationOff,
  // reference clock pad
  output logic refClkOut,
  output logic refClkBypass,
  output logic refClkOe,
  // packet settings
  output logic variableLength,
  output logic [6:0] txPayloadLen,
  output logic [6:0] rxMaxLen,
  output logic [2:0] preambleBytes,
  output logic manchesterEn,
  output logic whiteningEn,
  output logic crcEnable,
  // address filter
  input wire logic rxAddrValid,
  input wire logic [7:0] rxAddr,
  output logic rxAddrAccept,
  output logic rxAddrReject,
  // crc result and fifo
  input wire logic crcDoneValid,
  input wire logic crcOk,
  output logic fifoClear,
  input wire logic standbyMode,
  output logic fifoHostWrEn,
  output logic fifoHostRdEn
);

  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] regs_d [REG_COUNT];
  logic [6:0] regAddr;
  logic wrStrobe;
  logic [7:0] wrData, rdData;
  logic [3:0] regIdx;
  logic crcStatus_q, crcStatus_d;
  logic [31:0] rxShift_q, rxShift_d;
  logic [5:0] rxCount_q, rxCount_d;
  logic checkPend_q, checkPend_d;
  logic found_q, found_d;
  logic accept_q, accept_d, reject_q, reject_d;
  logic clear_q, clear_d;
  logic wrEn_q, wrEn_d, rdEn_q, rdEn_d;
  logic [2:0] preamble_q, preamble_d;
  logic signed [7:0] power_q, power_d;
  logic [11:0] cutoff_q, cutoff_d;
  logic [31:0] expected, mask;
  logic [5:0] needBits;
  logic [5:0] errors;
  rstopc_filt_t filtMode;

  // reset value of each register
  function automatic logic [7:0] resetOf(input int idx);
    case (idx)
      IDX_TX_SET: resetOf = RST_TX_SET;
      IDX_CLK_OUT: resetOf = RST_CLK_OUT;
      IDX_CODING: resetOf = RST_CODING;
      IDX_NODE: resetOf = RST_NODE;
      IDX_FRAME: resetOf = RST_FRAME;
      IDX_FIFO_POL: resetOf = RST_FIFO_POL;
      default: resetOf = RST_SYNC;
    endcase
  endfunction

  // writable bits of each register
  function automatic logic [7:0] maskOf(input int idx);
    case (idx)
      IDX_CLK_OUT: maskOf = MASK_CLK_OUT;
      IDX_FRAME: maskOf = MASK_FRAME;
      IDX_FIFO_POL: maskOf = MASK_FIFO_POL;
      default: maskOf = MASK_ALL;
    endcase
  endfunction

  // count of ones in a word
  function automatic logic [5:0] popCount(input logic [31:0] w);
    popCount = 6'd0;
    for (int i = 0; i < 32; i++)
    begin
      popCount = popCount + {5'd0, w[i]};
    end
  endfunction

  // serial port slave
  rstopc_spi_port u_spi (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .spiSck(spiSck),
    .spiCs_b(spiCs_b),
    .spiMosi(spiMosi),
    .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe),
    .regAddr(regAddr),
    .wrStrobe(wrStrobe),
    .wrData(wrData),
    .rdData(rdData)
  );

  assign regIdx = 4'(regAddr - ADDR_SYNC_HI);

  // register writes: status bit and reserved bits never change
  always_comb
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      regs_d[i] = regs_q[i];
      if (wrStrobe && regAddr >= ADDR_SYNC_HI && regAddr <= ADDR_FIFO_POL && int'(regIdx) == i)
      begin
        regs_d[i] = (regs_q[i] & ~maskOf(i)) | (wrData & maskOf(i));
      end
    end
  end

  // register file
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      if (!rst_b)
      begin
        regs_q[i] <= resetOf(i);
      end
      else
      begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // read mux, crc status merged into the frame register, unmapped reads zero
  always_comb
  begin
    rdData = 8'h00;
    if (regAddr >= ADDR_SYNC_HI && regAddr <= ADDR_FIFO_POL)
    begin
      rdData = regs_q[regIdx];
    end
    if (regAddr == ADDR_FRAME)
    begin
      rdData[FRM_CRCSTAT_BIT] = crcStatus_q;
    end
  end

  // expected pattern right-aligned to the size code, with its compare mask
  always_comb
  begin
    expected = {regs_q[IDX_SYNC_HI], regs_q[IDX_SYNC_2], regs_q[IDX_SYNC_3],
                regs_q[IDX_SYNC_LO]} >> (6'd8 * (6'd3 - {4'd0, syncSize}));
    mask = 32'hFFFFFFFF >> (6'd8 * (6'd3 - {4'd0, syncSize}));
    needBits = 6'd8 * ({4'd0, syncSize} + 6'd1);
    errors = popCount((rxShift_q ^ expected) & mask);
  end

  assign filtMode = rstopc_filt_t'(regs_q[IDX_FRAME][FRM_FILT_LSB +: 2]);

  // datapath events: sync detect, address filter, crc result, fifo access
  always_comb
  begin
    rxShift_d = rxShift_q;
    rxCount_d = rxCount_q;
    checkPend_d = 1'b0;
    found_d = 1'b0;
    accept_d = 1'b0;
    reject_d = 1'b0;
    clear_d = 1'b0;
    crcStatus_d = crcStatus_q;
    if (!syncEnable)
    begin
      rxCount_d = 6'd0;
    end
    else if (rxBitValid)
    begin
      rxShift_d = {rxShift_q[30:0], rxBit};
      rxCount_d = (rxCount_q == SYNC_MAX_BITS) ? rxCount_q : rxCount_q + 6'd1;
      checkPend_d = 1'b1;
    end
    if (checkPend_q && syncEnable && rxCount_q >= needBits && errors <= {4'd0, syncTol})
    begin
      found_d = 1'b1;
    end
    if (rxAddrValid)
    begin
      case (filtMode)
        FILT_OFF: accept_d = 1'b1;
        FILT_NODE: accept_d = (rxAddr == regs_q[IDX_NODE]);
        FILT_NODE_ZERO: accept_d = (rxAddr == regs_q[IDX_NODE]) || (rxAddr == 8'h00);
        FILT_NODE_ZERO_ONES: accept_d = (rxAddr == regs_q[IDX_NODE]) || (rxAddr == 8'h00)
                                        || (rxAddr == 8'hFF);
        default: accept_d = 1'b0;
      endcase
      reject_d = !accept_d;
    end
    if (crcDoneValid && regs_q[IDX_FRAME][FRM_CRC_BIT])
    begin
      crcStatus_d = crcOk;
      clear_d = !crcOk && !regs_q[IDX_FIFO_POL][FIFO_NOCLR_BIT];
    end
    wrEn_d = standbyMode && !regs_q[IDX_FIFO_POL][FIFO_DIR_BIT];
    rdEn_d = standbyMode && regs_q[IDX_FIFO_POL][FIFO_DIR_BIT];
    preamble_d = {1'b0, regs_q[IDX_FRAME][FRM_PREAMBLE_LSB +: 2]} + 3'd1;
    power_d = 8'(POWER_MAX_TENTH_DBM
                  - POWER_STEP_TENTH_DB * int'(regs_q[IDX_TX_SET][TX_POWER_LSB +: 3]));
    cutoff_d = 12'((CUTOFF_BASE_KHZ * XTAL_KHZ * (int'(regs_q[IDX_TX_SET][TX_CUTOFF_LSB +: 4]) + 1))
                   / (XTAL_REF_KHZ * CUTOFF_DIV));
  end

  // event and derived-setting registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rxShift_q <= 32'h00000000;
      rxCount_q <= 6'd0;
      checkPend_q <= 1'b0;
      found_q <= 1'b0;
      accept_q <= 1'b0;
      reject_q <= 1'b0;
      clear_q <= 1'b0;
      crcStatus_q <= 1'b0;
      wrEn_q <= 1'b0;
      rdEn_q <= 1'b0;
      preamble_q <= 3'd3;
      power_q <= 8'sh5F;
      cutoff_q <= 12'h0C8;
    end
    else
    begin
      rxShift_q <= rxShift_d;
      rxCount_q <= rxCount_d;
      checkPend_q <= checkPend_d;
      found_q <= found_d;
      accept_q <= accept_d;
      reject_q <= reject_d;
      clear_q <= clear_d;
      crcStatus_q <= crcStatus_d;
      wrEn_q <= wrEn_d;
      rdEn_q <= rdEn_d;
      preamble_q <= preamble_d;
      power_q <= power_d;
      cutoff_q <= cutoff_d;
    end
  end

  // reference clock output
  rstopc_clk_div u_clkdiv (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .outEnable(regs_q[IDX_CLK_OUT][CLK_EN_BIT]),
    .divField(regs_q[IDX_CLK_OUT][CLK_DIV_LSB +: 5]),
    .refClkOut(refClkOut),
    .refClkBypass(refClkBypass),
    .refClkOe(refClkOe)
  );

  // outputs taken from register fields and the event and derived-setting registers
  assign syncFound = found_q;
  assign txCutoffCode = regs_q[IDX_TX_SET][TX_CUTOFF_LSB +: 4];
  assign txCutoffKhz = cutoff_q;
  assign txPowerCode = regs_q[IDX_TX_SET][TX_POWER_LSB +: 3];
  assign txPowerTenthDbm = power_q;
  assign txFirstIfZero = regs_q[IDX_TX_SET][TX_ZEROIF_BIT];
  assign txDeviationOff = regs_q[IDX_TX_SET][TX_ZEROIF_BIT];
  assign variableLength = regs_q[IDX_FRAME][FRM_FORMAT_BIT];
  assign txPayloadLen = regs_q[IDX_CODING][6:0];
  assign rxMaxLen = regs_q[IDX_CODING][6:0];
  assign preambleBytes = preamble_q;
  assign manchesterEn = regs_q[IDX_CODING][CODE_MANCH_BIT];
  assign whiteningEn = regs_q[IDX_FRAME][FRM_WHITEN_BIT];
  assign crcEnable = regs_q[IDX_FRAME][FRM_CRC_BIT];
  assign rxAddrAccept = accept_q;
  assign rxAddrReject = reject_q;
  assign fifoClear = clear_q;
  assign fifoHostWrEn = wrEn_q;
  assign fifoHostRdEn = rdEn_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sync_needs_enable_a: assert property (syncFound |-> $past(syncEnable))
    else $error("sync found while recognition disabled");
  crc_status_load_a: assert property (crcDoneValid && crcEnable |=> crcStatus_q == $past(crcOk))
    else $error("crc status did not follow result");
  fifo_autoclear_a: assert property ((crcDoneValid && crcEnable && !crcOk
    && !regs_q[IDX_FIFO_POL][FIFO_NOCLR_BIT]) |=> fifoClear ##1 !fifoClear)
    else $error("fifo clear pulse wrong on crc fail");
  fifo_clear_cause_a: assert property (fifoClear |-> $past(!regs_q[IDX_FIFO_POL][FIFO_NOCLR_BIT]
    && crcDoneValid && !crcOk))
    else $error("fifo cleared without cause");
  host_fifo_dir_a: assert property (fifoHostWrEn |-> !fifoHostRdEn && $past(standbyMode))
    else $error("host fifo direction wrong");
  node_filter_a: assert property (rxAddrValid && filtMode == FILT_NODE
    && rxAddr != regs_q[IDX_NODE] |=> rxAddrReject && !rxAddrAccept)
    else $error("node filter accepted foreign address");
  ones_filter_a: assert property (rxAddrValid && filtMode == FILT_NODE_ZERO_ONES
    && rxAddr == 8'hFF |=> rxAddrAccept)
    else $error("all-ones address not accepted");
  status_write_guard_a: assert property (wrStrobe && regAddr == ADDR_FRAME
    |=> regs_q[IDX_FRAME] == {$past(wrData[7:1]), 1'b0})
    else $error("protected bit changed by write");
  preamble_len_a: assert property (##1 preambleBytes
    == 3'($past(regs_q[IDX_FRAME][FRM_PREAMBLE_LSB +: 2])) + 3'd1)
    else $error("preamble byte count wrong");
  clk_oe_follow_a: assert property ($past(rst_b)
    |-> refClkOe == $past(regs_q[IDX_CLK_OUT][CLK_EN_BIT]))
    else $error("reference clock enable mismatch");

endmodule

// ### design/rstopc_pkg.sv
// constants, field layout and reset values of the radio configuration bank
package rstopc_pkg;

  // register addresses on the serial configuration port
  localparam logic [6:0] ADDR_SYNC_HI = 7'h16;
  localparam logic [6:0] ADDR_SYNC_2 = 7'h17;
  localparam logic [6:0] ADDR_SYNC_3 = 7'h18;
  localparam logic [6:0] ADDR_SYNC_LO = 7'h19;
  localparam logic [6:0] ADDR_TX_SET = 7'h1A;
  localparam logic [6:0] ADDR_CLK_OUT = 7'h1B;
  localparam logic [6:0] ADDR_CODING = 7'h1C;
  localparam logic [6:0] ADDR_NODE = 7'h1D;
  localparam logic [6:0] ADDR_FRAME = 7'h1E;
  localparam logic [6:0] ADDR_FIFO_POL = 7'h1F;
  localparam int REG_COUNT = 10;

  // register indices relative to the first address
  localparam int IDX_SYNC_HI = 0;
  localparam int IDX_SYNC_2 = 1;
  localparam int IDX_SYNC_3 = 2;
  localparam int IDX_SYNC_LO = 3;
  localparam int IDX_TX_SET = 4;
  localparam int IDX_CLK_OUT = 5;
  localparam int IDX_CODING = 6;
  localparam int IDX_NODE = 7;
  localparam int IDX_FRAME = 8;
  localparam int IDX_FIFO_POL = 9;

  // reset values
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] RST_TX_SET = 8'h72;
  localparam logic [7:0] RST_CLK_OUT = 8'hBC;
  localparam logic [7:0] RST_CODING = 8'h00;
  localparam logic [7:0] RST_NODE = 8'h00;
  localparam logic [7:0] RST_FRAME = 8'h48;
  localparam logic [7:0] RST_FIFO_POL = 8'h00;

  // writable bits; the rest are reserved or read-only
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_CLK_OUT = 8'hFC;
  localparam logic [7:0] MASK_FRAME = 8'hFE;
  localparam logic [7:0] MASK_FIFO_POL = 8'hC0;

  // field positions
  localparam int TX_CUTOFF_LSB = 4;
  localparam int TX_POWER_LSB = 1;
  localparam int TX_ZEROIF_BIT = 0;
  localparam int CLK_EN_BIT = 7;
  localparam int CLK_DIV_LSB = 2;
  localparam int CODE_MANCH_BIT = 7;
  localparam int FRM_FORMAT_BIT = 7;
  localparam int FRM_PREAMBLE_LSB = 5;
  localparam int FRM_WHITEN_BIT = 4;
  localparam int FRM_CRC_BIT = 3;
  localparam int FRM_FILT_LSB = 1;
  localparam int FRM_CRCSTAT_BIT = 0;
  localparam int FIFO_NOCLR_BIT = 7;
  localparam int FIFO_DIR_BIT = 6;

  // cutoff and power scaling
  localparam int CUTOFF_BASE_KHZ = 200;
  localparam int XTAL_REF_KHZ = 12800;
  localparam int CUTOFF_DIV = 8;
  localparam int POWER_MAX_TENTH_DBM = 125;
  localparam int POWER_STEP_TENTH_DB = 30;

  // serial frame: command byte then data byte
  localparam logic [4:0] SPI_CMD_BITS = 5'd8;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd16;

  // sync word length ceiling in bits
  localparam logic [5:0] SYNC_MAX_BITS = 6'd32;

  // address filter modes in code order
  typedef enum logic [1:0] {FILT_OFF, FILT_NODE, FILT_NODE_ZERO, FILT_NODE_ZERO_ONES} rstopc_filt_t;

endpackage

// ### design/rstopc_spi_port.sv
// serial configuration port slave: byte command, byte data
`timescale 1ns/10ps
module rstopc_spi_port
  import rstopc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // pins from the host
  input wire logic spiSck,
  input wire logic spiCs_b,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // register side
  output logic [6:0] regAddr,
  output logic wrStrobe,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);

  logic [2:0] pinMeta_q, pinSync_q;
  logic sckLast_q;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [7:0] rxShift_q, rxShift_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] txShift_q, txShift_d;
  logic isRead_q, isRead_d;
  logic wr_q, wr_d;
  logic miso_q, miso_d;
  logic oe_q, oe_d;
  logic sckRise, sckFall, csActive;

  // two-stage synchronisers for sck, cs and mosi
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pinMeta_q <= 3'h4; // idle levels: cs high, sck low
      pinSync_q <= 3'h4;
      sckLast_q <= 1'b0;
    end
    else
    begin
      pinMeta_q <= {spiCs_b, spiMosi, spiSck};
      pinSync_q <= pinMeta_q;
      sckLast_q <= pinSync_q[0];
    end
  end

  assign csActive = !pinSync_q[2];
  assign sckRise = csActive && pinSync_q[0] && !sckLast_q;
  assign sckFall = csActive && !pinSync_q[0] && sckLast_q;

  // shift in on rising sck, shift read data out on falling sck
  always_comb
  begin
    bitCnt_d = bitCnt_q;
    rxShift_d = rxShift_q;
    addr_d = addr_q;
    txShift_d = txShift_q;
    isRead_d = isRead_q;
    wr_d = 1'b0;
    miso_d = miso_q;
    oe_d = csActive;
    if (!csActive)
    begin
      bitCnt_d = 5'd0;
    end
    else if (sckRise)
    begin
      rxShift_d = {rxShift_q[6:0], pinSync_q[1]};
      bitCnt_d = (bitCnt_q == SPI_FRAME_BITS - 5'd1) ? 5'd0 : bitCnt_q + 5'd1;
      if (bitCnt_q == SPI_CMD_BITS - 5'd1)
      begin
        isRead_d = rxShift_q[6];
        addr_d = rxShift_d[6:0];
      end
      if (bitCnt_q == SPI_FRAME_BITS - 5'd1)
      begin
        wr_d = !isRead_q; // ignored for reads
      end
    end
    else if (sckFall && bitCnt_q == SPI_CMD_BITS)
    begin
      miso_d = rdData[7];
      txShift_d = {rdData[6:0], 1'b0};
    end
    else if (sckFall && bitCnt_q > SPI_CMD_BITS)
    begin
      miso_d = txShift_q[7];
      txShift_d = {txShift_q[6:0], 1'b0};
    end
  end

  // frame state registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      bitCnt_q <= 5'd0;
      rxShift_q <= 8'h00;
      addr_q <= 7'h00;
      txShift_q <= 8'h00;
      isRead_q <= 1'b0;
      wr_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      bitCnt_q <= bitCnt_d;
      rxShift_q <= rxShift_d;
      addr_q <= addr_d;
      txShift_q <= txShift_d;
      isRead_q <= isRead_d;
      wr_q <= wr_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
    end
  end

  assign regAddr = addr_q;
  assign wrStrobe = wr_q;
  assign wrData = rxShift_q;
  assign spiMiso = miso_q;
  assign spiMisoOe = oe_q;

endmodule

// ### verification/rstopc_host_model.sv
// host serial master model driving the configuration port
`timescale 1ns/10ps
module rstopc_host_model
(
  // clock
  core_clk,
  // serial pins
  spiSck,
  spiCs_b,
  spiMosi,
  spiMiso
);
  input wire logic core_clk;
  output logic spiSck;
  output logic spiCs_b;
  output logic spiMosi;
  input wire logic spiMiso;
  logic idle = 1'b1;
  initial
  begin
    spiSck = 1'b0;
    spiCs_b = 1'b1;
    spiMosi = 1'b0;
  end
  // data line keeps changing while deselected so a stale bit never looks valid
  always @(negedge core_clk)
    if (idle)
      spiMosi <= ~spiMosi;
  // one whole frame: command byte then data byte, msb first, mode 0
  task automatic xfer(input logic rdn, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [15:0] sh;
    sh = {rdn, a, wd};
    q = 8'h00;
    // stop the idle toggling before the edge that opens the frame
    idle = 1'b0;
    @(negedge core_clk);
    spiCs_b = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spiMosi = sh[i];
      repeat (5) @(negedge core_clk);
      spiSck = 1'b1;
      if (i < 8)
        q[i] = spiMiso;
      repeat (5) @(negedge core_clk);
      spiSck = 1'b0;
    end
    repeat (6) @(negedge core_clk);
    spiCs_b = 1'b1;
    idle = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the radio configuration bank
`timescale 1ns/10ps
module tb;
  import rstopc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic spiSck, spiCs_b, spiMosi, spiMiso, spiMisoOe, syncFound;
  logic syncEnable = 1'b0, rxBitValid = 1'b0, rxBit = 1'b0, rxAddrValid = 1'b0;
  logic crcDoneValid = 1'b0, crcOk = 1'b0, standbyMode = 1'b0;
  logic [1:0] syncSize = 2'b00, syncTol = 2'b00;
  logic [7:0] rxAddr = 8'h00;
  logic [3:0] txCutoffCode;
  logic [11:0] txCutoffKhz;
  logic [2:0] txPowerCode, preambleBytes;
  logic signed [7:0] txPowerTenthDbm;
  logic txFirstIfZero, txDeviationOff, refClkOut, refClkBypass, refClkOe, variableLength;
  logic [6:0] txPayloadLen, rxMaxLen;
  logic manchesterEn, whiteningEn, crcEnable, rxAddrAccept, rxAddrReject, fifoClear;
  logic fifoHostWrEn, fifoHostRdEn;
  int err_total = 0, n_compared = 0, cyc = 0, accN = 0, rejN = 0, clrN = 0, synN = 0;
  localparam logic [7:0] RSTV [10] = '{RST_SYNC, RST_SYNC, RST_SYNC, RST_SYNC, RST_TX_SET,
    RST_CLK_OUT, RST_CODING, RST_NODE, RST_FRAME, RST_FIFO_POL};
  localparam logic [7:0] MSK [10] = '{MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL,
    MASK_CLK_OUT, MASK_ALL, MASK_ALL, MASK_FRAME, MASK_FIFO_POL};

  rstopc_config dut (.core_clk(core_clk), .rst_b(rst_b), .spiSck(spiSck), .spiCs_b(spiCs_b),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .syncEnable(syncEnable),
    .syncSize(syncSize), .syncTol(syncTol), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .syncFound(syncFound), .txCutoffCode(txCutoffCode), .txCutoffKhz(txCutoffKhz),
    .txPowerCode(txPowerCode), .txPowerTenthDbm(txPowerTenthDbm),
    .txFirstIfZero(txFirstIfZero), .txDeviationOff(txDeviationOff), .refClkOut(refClkOut),
    .refClkBypass(refClkBypass), .refClkOe(refClkOe), .variableLength(variableLength),
    .txPayloadLen(txPayloadLen), .rxMaxLen(rxMaxLen), .preambleBytes(preambleBytes),
    .manchesterEn(manchesterEn), .whiteningEn(whiteningEn), .crcEnable(crcEnable),
    .rxAddrValid(rxAddrValid), .rxAddr(rxAddr), .rxAddrAccept(rxAddrAccept),
    .rxAddrReject(rxAddrReject), .crcDoneValid(crcDoneValid), .crcOk(crcOk),
    .fifoClear(fifoClear), .standbyMode(standbyMode), .fifoHostWrEn(fifoHostWrEn),
    .fifoHostRdEn(fifoHostRdEn));
  rstopc_host_model host (.core_clk(core_clk), .spiSck(spiSck), .spiCs_b(spiCs_b),
    .spiMosi(spiMosi), .spiMiso(spiMiso));

  // clock generation
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // pulse counters and hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    accN += rxAddrAccept;
    rejN += rxAddrReject;
    clrN += fifoClear;
    synN += syncFound;
    if (cyc == 60000)
    begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b1, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  // one-cycle strobe on an input, then settle
  task automatic strobe(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  // reset values on registers and decoded outputs
  task automatic t_reset();
    chk(16'(preambleBytes), 16'd3);
    chk(16'(txPowerTenthDbm), 16'd95);
    chk(16'(txCutoffKhz), 16'd200);
    chk({15'h0, refClkOe}, 16'h1);
    chk({15'h0, spiMisoOe}, 16'h0);
    chk({manchesterEn, whiteningEn, variableLength, crcEnable, 12'h0}, 16'h1000);
    for (int i = 0; i < REG_COUNT; i++)
      rdc(7'(ADDR_SYNC_HI + i), RSTV[i]);
  endtask
  // all ones then all zeros; reserved and status bits hold, unmapped reads zero
  task automatic t_regs();
    for (int i = 0; i < REG_COUNT; i++)
    begin
      wr(7'(ADDR_SYNC_HI + i), 8'hFF);
      rdc(7'(ADDR_SYNC_HI + i), (RSTV[i] & ~MSK[i]) | MSK[i]);
    end
    chk({manchesterEn, whiteningEn, variableLength, crcEnable, 5'h0, txPayloadLen},
        16'hF07F);
    chk(16'(rxMaxLen), 16'h7F);
    for (int i = 0; i < REG_COUNT; i++)
    begin
      wr(7'(ADDR_SYNC_HI + i), 8'h00);
      rdc(7'(ADDR_SYNC_HI + i), RSTV[i] & ~MSK[i]);
    end
    chk({manchesterEn, whiteningEn, variableLength, crcEnable, refClkOe}, 16'h0);
    wr(7'h20, 8'hFF);
    rdc(7'h20, 8'h00);
  endtask
  // cutoff, power and zero-IF decode across all power codes
  task automatic t_tx();
    for (int n = 0; n < 8; n++)
    begin
      wr(ADDR_TX_SET, {4'(2 * n), 3'(n), 1'(n)});
      chk(16'(txCutoffKhz), 16'(25 * (2 * n + 1)));
      chk({9'h0, txCutoffCode, txPowerCode}, {9'h0, 4'(2 * n), 3'(n)});
      chk(16'(txPowerTenthDbm), 16'(125 - 30 * n));
      chk({txFirstIfZero, txDeviationOff}, {2{1'(n)}});
    end
  endtask
  // undivided bypass, divided high phase, disabled pad
  task automatic t_clk();
    int k;
    wr(ADDR_CLK_OUT, 8'h80);
    chk({refClkBypass, refClkOe}, 16'h3);
    wr(ADDR_CLK_OUT, 8'h8C);
    k = 0;
    while (refClkOut !== 1'b0 && k < 20)
    begin
      @(negedge core_clk);
      k++;
    end
    while (refClkOut !== 1'b1 && k < 20)
    begin
      @(negedge core_clk);
      k++;
    end
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end while (refClkOut !== 1'b0 && k < 20);
    chk({refClkBypass, 15'(k)}, 16'd3);
    wr(ADDR_CLK_OUT, 8'h0C);
    chk({15'h0, refClkOe}, 16'h0);
  endtask
  // preamble codes and every address filter mode
  task automatic t_pkt();
    logic [7:0] ad [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
    int a0, r0;
    logic ok;
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_FRAME, {1'b0, 2'(k), 5'h0});
      chk(16'(preambleBytes), 16'(k + 1));
    end
    wr(ADDR_NODE, 8'h5A);
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_FRAME, {5'h0, 2'(m), 1'b0});
      for (int j = 0; j < 4; j++)
      begin
        ok = m == 0 || j == 0 || (m >= 2 && j == 1) || (m == 3 && j == 2);
        rxAddr = ad[j];
        a0 = accN;
        r0 = rejN;
        strobe(rxAddrValid);
        chk(16'(accN - a0) << 4 | 16'(rejN - r0), {11'h0, ok, 3'h0, !ok});
      end
    end
  endtask
  // crc status, auto clear on failure, standby fifo direction
  task automatic t_crc();
    int c0;
    wr(ADDR_FRAME, 8'h08);
    for (int j = 0; j < 3; j++)
    begin
      wr(ADDR_FIFO_POL, j == 2 ? 8'h80 : 8'h00);
      crcOk = j == 1;
      c0 = clrN;
      strobe(crcDoneValid);
      chk(16'(clrN - c0), 16'(j == 0));
      rdc(ADDR_FRAME, {7'h04, crcOk});
    end
    standbyMode = 1'b1;
    wr(ADDR_FIFO_POL, 8'h00);
    chk({fifoHostWrEn, fifoHostRdEn}, 16'h2);
    wr(ADDR_FIFO_POL, 8'h40);
    chk({fifoHostWrEn, fifoHostRdEn}, 16'h1);
  endtask
  // sync word: byte order, error tolerance, enable gating
  task automatic t_sync();
    logic [38:0] cs [9] = '{{1'b1, 2'd0, 2'd0, 32'hA5, 1'b1, 1'b0},
      {1'b1, 2'd0, 2'd0, 32'hA4, 1'b0, 1'b0}, {1'b1, 2'd0, 2'd1, 32'hA4, 1'b1, 1'b0},
      {1'b1, 2'd0, 2'd3, 32'hA2, 1'b1, 1'b0}, {1'b1, 2'd1, 2'd0, 32'hA53C, 1'b1, 1'b0},
      {1'b0, 2'd0, 2'd0, 32'hA5, 1'b0, 1'b0}, {1'b1, 2'd2, 2'd0, 32'hA53C96, 1'b1, 1'b0},
      {1'b1, 2'd3, 2'd0, 32'hA53C960F, 1'b1, 1'b0},
      {1'b1, 2'd3, 2'd3, 32'hA53C96F0, 1'b0, 1'b0}};
    int s0;
    wr(ADDR_SYNC_HI, 8'hA5);
    wr(ADDR_SYNC_2, 8'h3C);
    wr(ADDR_SYNC_3, 8'h96);
    wr(ADDR_SYNC_LO, 8'h0F);
    for (int c = 0; c < 9; c++)
    begin
      syncEnable = 1'b0;
      repeat (2) @(negedge core_clk);
      {syncEnable, syncSize, syncTol} = cs[c][38:34];
      s0 = synN;
      for (int i = 8 * (syncSize + 1) - 1; i >= 0; i--)
      begin
        rxBit = cs[c][i + 2];
        strobe(rxBitValid);
      end
      chk(16'(synN - s0), 16'(cs[c][1]));
    end
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_regs();
    t_tx();
    t_clk();
    t_pkt();
    t_crc();
    t_sync();
    results();
  end
endmodule
